// ==== verilog/psr_pkg.sv ====
// Package: register map, field layout and status types of the status block
package psr_pkg;

  localparam logic [7:0] REG_STATUS_ONE   = 8'h05;
  localparam logic [7:0] REG_STATUS_TWO   = 8'h06;
  localparam logic [7:0] REG_EVENT_FLAGS  = 8'h07;
  localparam logic [7:0] REG_EVENT_MASK   = 8'h08;
  localparam logic [7:0] REG_LINK_STATUS  = 8'h0a;

  localparam logic [7:0] RST_STATUS_TWO   = 8'h00;
  localparam logic [7:0] RST_EVENT_FLAGS  = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK   = 8'h10;
  localparam logic [7:0] MASK_WRITABLE    = 8'h7f;
  localparam logic [2:0] RST_STATE_CODE   = 3'h0;
  localparam logic [2:0] RST_PRIME_COUNT  = 3'h0;
  localparam logic [2:0] PRIME_CYCLES     = 3'h5;

  localparam int FLD_TIMER_LO       = 6;
  localparam int FLD_SUMMARY        = 5;
  localparam int FLD_CODE_LO        = 2;
  localparam int FLD_ADDR_SELECT    = 1;
  localparam int FLD_LINK_ADDRESS   = 0;
  localparam int FLD_DROPOUT_LEVEL  = 7;
  localparam int FLD_ENABLE_LEVEL   = 6;
  localparam int FLD_INTERNAL_LO    = 2;
  localparam int FLD_THERMAL_LEVEL  = 1;
  localparam int FLD_COMPARATOR     = 0;

  localparam int BIT_STATE_CHANGE   = 0;
  localparam int BIT_LINK_SUMMARY   = 1;
  localparam int BIT_CHARGE_TIMER   = 2;
  localparam int BIT_DROPOUT        = 3;
  localparam int BIT_RESISTOR_DONE  = 4;
  localparam int BIT_THERMAL        = 5;
  localparam int BIT_LINE_SHORT     = 6;

  localparam logic [1:0] TIMER_INACTIVE = 2'h0;
  localparam logic [1:0] TIMER_RUNNING  = 2'h1;
  localparam logic [1:0] TIMER_EXPIRED  = 2'h2;
  localparam logic [1:0] TIMER_RESERVED = 2'h3;

  localparam logic [6:0] TARGET_ADDR_LOW  = 7'h15;
  localparam logic [6:0] TARGET_ADDR_HIGH = 7'h6a;

  // Live inputs from the analogue and state-machine side
  typedef struct packed {
    logic [1:0] charge_timer_state;
    logic [2:0] state_machine_code;
    logic       target_addr_select;
    logic       link_address_select;
    logic       regulator_dropout_level;
    logic       enable_pin_level;
    logic       thermal_shutdown_level;
    logic       line_comparator_out;
    logic [3:0] internal_bits;
    logic       resistor_measure_done;
    logic       line_short_detect;
  } psr_status_in_t;

  // Register bus request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psr_bus_req_t;

endpackage

// ==== verilog/psr_sync.sv ====
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module psr_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // psr_sync

// ==== verilog/psr_event_flags.sv ====
// Sticky event flags, cleared together on a read, set winning over clear
`timescale 1ns/1ps
module psr_event_flags
  import psr_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] set_i,
  input  wire logic       clear_i,
  output logic      [7:0] flags_o
);
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flags_o <= RST_EVENT_FLAGS;
    end else if (clear_i) begin
      flags_o <= set_i & MASK_WRITABLE;
    end else begin
      flags_o <= (flags_o | set_i) & MASK_WRITABLE;
    end
  end
endmodule // psr_event_flags

// ==== verilog/psr_status_regs.sv ====
// Status, event flag and event mask registers of the link management device
`timescale 1ns/1ps
// Function
// - Charge timer state at status one bits 7:6; code 3 never shown.
// - Bit 5 high when any link status register bit is set.
// - State machine code shown in status one bits 4:2.
// - Bit 1 shows which of two target addresses is configured.
// - Bit 0 gives link address or single/dual target mode by role.
// - Status two bit 7 follows the regulator dropout comparator.
// - Status two bit 6 follows the enable pin level.
// - Status two bit 1 set while in thermal shutdown.
// - Status two bit 0 shows the line comparator output.
// - Status two bits 5:2 are internal and carry no meaning.
// - Event bit 0 latches on any state machine code change.
// - Event bit 1 latches on any link summary change.
// - Event bit 2 latches when charge timer goes running to expired.
// - Event bit 3 raised on regulator dropout.
// - Event bit 4 set when resistor measurement completes.
// - Event bit 5 set when over thermal shutdown threshold.
// - Event bit 6 set on line short; bit 7 reserved.
// - One mask bit per flag; 1 lets the flag interrupt.
// - Link status register is read only.
module psr_status_regs
  import psr_pkg::*;
(
  input  wire logic           clock_i,
  input  wire logic           reset_i,
  input  wire psr_status_in_t status_i,
  input  wire logic [7:0]     link_status_register_i,
  input  wire psr_bus_req_t   bus_i,
  output logic      [7:0]     rdata_o,
  output logic                rvalid_o,
  output logic                interrupt_n_o,
  output logic      [6:0]     target_address_o
);

  localparam int ST_W = $bits(psr_status_in_t);

  psr_status_in_t   live;
  logic [ST_W-1:0]  live_bits;
  logic [7:0]       link_sync;
  logic [7:0]       status_one;
  logic [7:0]       status_two;
  logic [7:0]       event_mask;
  logic [7:0]       event_flags;
  logic [7:0]       next_set;
  logic [2:0]       prev_code;
  logic             prev_summary;
  logic [1:0]       prev_timer;
  logic             prev_done;
  logic             primed;
  logic             link_status_summary;
  logic [1:0]       charge_timer_state;
  logic [2:0]       code_seen;
  logic [2:0]       code_held;
  logic [1:0]       timer_seen;
  logic [1:0]       timer_held;
  logic [2:0]       prime_count;
  logic             flags_read;
  logic             mask_write;
  logic [7:0]       pending;
  logic [7:0]       read_word;

  // Pins arrive from other domains
  psr_sync #(.W(ST_W)) u_sync_status (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .async_i (status_i),
    .sync_o  (live_bits)
  );

  psr_sync #(.W(8)) u_sync_link (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .async_i (link_status_register_i),
    .sync_o  (link_sync)
  );

  assign live = psr_status_in_t'(live_bits);

  // Register offset decode
  function automatic logic reg_hit(input psr_bus_req_t req, input logic [7:0] offset);
    return req.addr == offset;
  endfunction

  // Reserved timer code shown as expired
  function automatic logic [1:0] timer_shown(input logic [1:0] code);
    return (code == TIMER_RESERVED) ? TIMER_EXPIRED : code;
  endfunction

  // Last sample of the state code
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      code_seen <= RST_STATE_CODE;
    end else begin
      code_seen <= live.state_machine_code;
    end
  end

  // Last sample of the timer word
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timer_seen <= TIMER_INACTIVE;
    end else begin
      timer_seen <= live.charge_timer_state;
    end
  end

  // State code taken after two equal samples
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      code_held <= RST_STATE_CODE;
    end else if (live.state_machine_code == code_seen) begin
      code_held <= code_seen;
    end
  end

  // Timer word taken after two equal samples
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timer_held <= TIMER_INACTIVE;
    end else if (live.charge_timer_state == timer_seen) begin
      timer_held <= timer_seen;
    end
  end

  assign link_status_summary = |link_sync;

  assign charge_timer_state = timer_shown(timer_held);

  // Status one fields
  always_comb begin
    status_one = 8'h00;
    status_one[FLD_TIMER_LO +: 2] = charge_timer_state;
    status_one[FLD_SUMMARY] = link_status_summary;
    status_one[FLD_CODE_LO +: 3] = code_held;
    status_one[FLD_ADDR_SELECT] = live.target_addr_select;
    status_one[FLD_LINK_ADDRESS] = live.link_address_select;
  end

  // Status two fields
  always_comb begin
    status_two = 8'h00;
    status_two[FLD_DROPOUT_LEVEL] = live.regulator_dropout_level;
    status_two[FLD_ENABLE_LEVEL] = live.enable_pin_level;
    status_two[FLD_INTERNAL_LO +: 4] = live.internal_bits;
    status_two[FLD_THERMAL_LEVEL] = live.thermal_shutdown_level;
    status_two[FLD_COMPARATOR] = live.line_comparator_out;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      target_address_o <= TARGET_ADDR_LOW;
    end else begin
      target_address_o <= live.target_addr_select ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;
    end
  end

  // State code and link summary change detection waits for real samples
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prime_count <= RST_PRIME_COUNT;
    end else if (prime_count != PRIME_CYCLES) begin
      prime_count <= prime_count + 3'h1;
    end
  end

  assign primed = (prime_count == PRIME_CYCLES);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_code <= RST_STATE_CODE;
    end else begin
      prev_code <= code_held;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_summary <= 1'b0;
    end else begin
      prev_summary <= link_status_summary;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_timer <= TIMER_INACTIVE;
    end else begin
      prev_timer <= charge_timer_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_done <= 1'b0;
    end else begin
      prev_done <= live.resistor_measure_done;
    end
  end

  always_comb begin
    next_set = 8'h00;
    next_set[BIT_STATE_CHANGE] = primed && (code_held != prev_code);
    next_set[BIT_LINK_SUMMARY] = primed && (link_status_summary != prev_summary);
    next_set[BIT_CHARGE_TIMER] = (prev_timer == TIMER_RUNNING) &&
                                 (charge_timer_state == TIMER_EXPIRED);
    next_set[BIT_DROPOUT] = live.regulator_dropout_level;
    next_set[BIT_RESISTOR_DONE] = live.resistor_measure_done && !prev_done;
    next_set[BIT_THERMAL] = live.thermal_shutdown_level;
    // line short, bit 7 stays zero
    next_set[BIT_LINE_SHORT] = live.line_short_detect;
  end

  assign flags_read = bus_i.rd && reg_hit(bus_i, REG_EVENT_FLAGS);

  assign mask_write = bus_i.wr && reg_hit(bus_i, REG_EVENT_MASK);

  psr_event_flags u_flags (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .set_i   (next_set),
    .clear_i (flags_read),
    .flags_o (event_flags)
  );

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      event_mask <= RST_EVENT_MASK;
    end else if (mask_write) begin
      event_mask <= bus_i.wdata & MASK_WRITABLE;
    end
  end

  // Read multiplexer
  always_comb begin
    read_word = 8'h00;
    case (bus_i.addr)
      REG_STATUS_ONE:  read_word = status_one;
      REG_STATUS_TWO:  read_word = status_two;
      REG_EVENT_FLAGS: read_word = event_flags;
      REG_EVENT_MASK:  read_word = event_mask;
      REG_LINK_STATUS: read_word = link_sync;
      default:         read_word = 8'h00;
    endcase
  end

  // Read answer pulse
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= bus_i.rd;
    end
  end

  // Read data held until next read
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_o <= read_word;
    end
  end

  assign pending = event_flags & event_mask;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      interrupt_n_o <= 1'b1;
    end else begin
      interrupt_n_o <= ~|pending;
    end
  end

endmodule // psr_status_regs

// ==== sim/psr_status_regs_chk.sv ====
// Port assertions for the status block
`timescale 1ns/1ps
module psr_status_regs_chk
  import psr_pkg::*;
(
  input wire logic           clock_i,
  input wire logic           reset_i,
  input wire psr_status_in_t status_i,
  input wire logic [7:0]     link_status_register_i,
  input wire psr_bus_req_t   bus_i,
  input wire logic [7:0]     rdata_o,
  input wire logic           rvalid_o,
  input wire logic           interrupt_n_o,
  input wire logic [6:0]     target_address_o
);
  logic [3:0] stab;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Cycles with inputs unchanged
  always_ff @(posedge clock_i) begin
    if (reset_i || $changed({status_i, link_status_register_i})) begin
      stab <= 4'h0;
    end else if (stab != 4'hf) begin
      stab <= stab + 4'h1;
    end
  end
  property p_answer;
    1'b1 |=> rvalid_o == $past(bus_i.rd);
  endproperty
  a_answer: assert property (p_answer) else $error("read answer timing");
  property p_target;
    status_i.target_addr_select [*4] |-> target_address_o == TARGET_ADDR_HIGH;
  endproperty
  a_target: assert property (p_target) else $error("target address");
  property p_target_low;
    (!status_i.target_addr_select) [*4] |-> target_address_o == TARGET_ADDR_LOW;
  endproperty
  a_target_low: assert property (p_target_low) else $error("target address low");
  property p_st1;
    bus_i.rd && bus_i.addr == REG_STATUS_ONE && stab > 4'h4 |=>
      rdata_o[5:0] == {|$past(link_status_register_i, 2), $past(status_i.state_machine_code, 2),
      $past(status_i.target_addr_select, 2), $past(status_i.link_address_select, 2)};
  endproperty
  a_st1: assert property (p_st1) else $error("status one");
  property p_st2;
    bus_i.rd && bus_i.addr == REG_STATUS_TWO && stab > 4'h4 |=>
      {rdata_o[7:6], rdata_o[1:0]} == {$past(status_i.regulator_dropout_level, 2),
      $past(status_i.enable_pin_level, 2), $past(status_i.thermal_shutdown_level, 2),
      $past(status_i.line_comparator_out, 2)};
  endproperty
  a_st2: assert property (p_st2) else $error("status two");
  property p_flag7;
    bus_i.rd && bus_i.addr == REG_EVENT_FLAGS |=> !rdata_o[7];
  endproperty
  a_flag7: assert property (p_flag7) else $error("flag bit 7 set");
  property p_mask7;
    bus_i.rd && bus_i.addr == REG_EVENT_MASK |=> !rdata_o[7];
  endproperty
  a_mask7: assert property (p_mask7) else $error("mask bit 7 set");
  property p_link;
    bus_i.rd && bus_i.addr == REG_LINK_STATUS && stab > 4'h4 |=>
      rdata_o == $past(link_status_register_i, 2);
  endproperty
  a_link: assert property (p_link) else $error("link status");
  property p_quiet;
    bus_i.rd && bus_i.addr == REG_EVENT_FLAGS && stab > 4'h4 && !status_i.line_short_detect
      && !status_i.regulator_dropout_level && !status_i.thermal_shutdown_level
      |-> ##2 interrupt_n_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt after clear");
endmodule // psr_status_regs_chk

// ==== sim/psr_host.sv ====
// Host model issuing register requests
`timescale 1ns/1ps
module psr_host
  import psr_pkg::*;
(
  input  wire logic   clock_i,
  output psr_bus_req_t bus_o
);
  initial bus_o = '0;
  // One request held over its edge
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    bus_o <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clock_i);
    bus_o <= '0;
    @(posedge clock_i);
  endtask
endmodule // psr_host

// ==== sim/psr_status_regs_tb_top.sv ====
// Testbench for the status, event flag and mask registers
`timescale 1ns/1ps
module psr_status_regs_tb_top
  import psr_pkg::*;
;
  logic           clock_i = 0, reset_i = 1, rvalid_o, interrupt_n_o;
  psr_status_in_t st = '0, p;
  logic [7:0]     lk = '0, pl, rdata_o, m, fl;
  logic [6:0]     target_address_o;
  psr_bus_req_t   bus;
  logic [15:0]    exp_q[$], q;
  int             failures = 0, samples_checked = 0, seed = 91;
  initial forever #25 clock_i = ~clock_i;
  psr_host psr_host_i (.clock_i(clock_i), .bus_o(bus));
  psr_status_regs psr_status_regs_i (.clock_i(clock_i), .reset_i(reset_i), .status_i(st),
    .link_status_register_i(lk), .bus_i(bus), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .interrupt_n_o(interrupt_n_o), .target_address_o(target_address_o));
  task check(input string w, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  task give_verdict;
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k = 8'hff);
    exp_q.push_back({k, e & k});
    psr_host_i.xfer(1'b1, a, 8'h00);
  endtask
  task irq(input logic e);
    repeat (2) @(negedge clock_i);
    check("interrupt", {7'h0, interrupt_n_o}, {7'h0, e});
    @(posedge clock_i);
  endtask
  always @(negedge clock_i) if (rvalid_o === 1'b1) begin
    q = exp_q.size() ? exp_q.pop_front() : 16'h00xx;
    check("rdata", rdata_o & q[15:8], q[7:0]);
  end
  initial begin
    #100us;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(REG_EVENT_FLAGS, RST_EVENT_FLAGS);
    rd(REG_EVENT_MASK, RST_EVENT_MASK);
    rd(REG_STATUS_TWO, RST_STATUS_TWO);
    rd(8'h20, 8'h00);
    st.resistor_measure_done <= 1'b1;
    repeat (6) @(posedge clock_i);
    irq(1'b0);
    rd(REG_EVENT_FLAGS, 8'h10);
    irq(1'b1);
    p = st;
    pl = lk;
    for (int i = 0; i < 24; i++) begin
      st <= psr_status_in_t'(17'($random(seed)) | 17'h2);
      lk <= 8'($random(seed));
      m = 8'($random(seed)) & MASK_WRITABLE;
      psr_host_i.xfer(1'b0, REG_EVENT_MASK, m);
      repeat (4) @(posedge clock_i);
      fl = {1'b0, p.line_short_detect | st.line_short_detect,
        p.thermal_shutdown_level | st.thermal_shutdown_level, 1'b0,
        p.regulator_dropout_level | st.regulator_dropout_level,
        p.charge_timer_state == TIMER_RUNNING && st.charge_timer_state[1],
        (|pl) != (|lk), p.state_machine_code != st.state_machine_code};
      irq(~|(fl & m));
      check("target", {1'b0, target_address_o}, {1'b0, st.target_addr_select ?
        TARGET_ADDR_HIGH : TARGET_ADDR_LOW});
      rd(REG_STATUS_ONE, {(st.charge_timer_state == 2'h3) ? TIMER_EXPIRED : st.charge_timer_state,
        |lk, st.state_machine_code, st.target_addr_select, st.link_address_select});
      rd(REG_STATUS_TWO, {st.regulator_dropout_level, st.enable_pin_level, 4'h0,
        st.thermal_shutdown_level, st.line_comparator_out}, 8'hc3);
      rd(REG_LINK_STATUS, lk);
      rd(REG_EVENT_MASK, m);
      rd(REG_EVENT_FLAGS, fl);
      p = st;
      pl = lk;
    end
    give_verdict();
  end
endmodule // psr_status_regs_tb_top
bind psr_status_regs psr_status_regs_chk psr_status_regs_chk_i (.clock_i(clock_i),
  .reset_i(reset_i), .status_i(status_i), .link_status_register_i(link_status_register_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .interrupt_n_o(interrupt_n_o),
  .target_address_o(target_address_o));
